// ---- core/pcoc_top.sv ----
// position compare output block with APB register access
`timescale 1ns/10ps
`default_nettype none
module pcoc_top
    import pcoc_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = PW_UNIT_CYC
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pos_up,
    input  wire logic        pos_dn,
    output logic             cmp_out
);
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        out_reg;
    logic [2:0]  func_reg;
    logic [15:0] adj_reg;
    logic [3:0]  mode_reg;
    logic [13:0] pw_reg;
    logic [31:0] bias_reg;
    logic [2:0]  attr_mem [NPTS];
    logic [31:0] tgt_mem [NPTS];
    logic [31:0] pos_reg;
    logic [4:0]  pt_reg;
    pcoc_state_t state_reg;
    logic        st_org_reg;
    logic        st_adj_reg;
    logic        org_pend_reg;
    logic        adj_pend_reg;
    logic        lvl_reg;
    logic [13:0] pw_left_reg;
    logic [23:0] ucnt_reg;
    logic [13:0] idx;
    logic        setup;
    logic        wr;
    logic        func_wr;
    logic [2:0]  rise;
    logic        hit;
    logic        fire;
    logic        last_pt;
    logic [31:0] rd_next;
    logic        map_next;

    function automatic logic in_tbl(input logic [13:0] i, input logic [13:0] b);
        return (i >= b) && (i < b + 14'(NPTS));
    endfunction
    function automatic logic [4:0] tbl_off(input logic [13:0] i, input logic [13:0] b);
        logic [13:0] d;
        d = i - b;
        return d[4:0];
    endfunction

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign cmp_out = out_reg;
    assign idx     = paddr[15:2];
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite && pready_reg && !pslverr_reg;
    assign func_wr = wr && (idx == IDX_FUNC);
    assign rise    = pwdata[2:0] & ~func_reg;
    assign last_pt = (pt_reg == LAST_PT);
    assign hit     = (state_reg == ST_RUN) && (pos_reg == tgt_mem[pt_reg]);
    // attribute 0 passes the point without an output action
    assign fire    = hit && (attr_mem[pt_reg] != 3'h0);

    // read mux; unmapped indices answer with an error
    always_comb
    begin
        rd_next  = 32'h0000_0000;
        map_next = 1'b1;
        if (in_tbl(idx, IDX_ATTR0))
            rd_next = {29'h0000_0000, attr_mem[tbl_off(idx, IDX_ATTR0)]};
        else if (in_tbl(idx, IDX_TGT0))
            rd_next = tgt_mem[tbl_off(idx, IDX_TGT0)];
        else
        begin
            case (idx)
                IDX_FUNC:  rd_next = {29'h0000_0000, func_reg};
                IDX_ADJ:   rd_next = {16'h0000, adj_reg};
                IDX_STAT:  rd_next = {29'h0000_0000, st_adj_reg, st_org_reg, state_reg == ST_RUN};
                IDX_TPT:   rd_next = {27'h0000_000, pt_reg};
                IDX_POS:   rd_next = {16'h0000, pos_reg[15:0]};
                IDX_POS32: rd_next = pos_reg;
                IDX_MODE:  rd_next = {28'h0000_000, mode_reg};
                IDX_PW:    rd_next = {18'h0_0000, pw_reg};
                IDX_BIAS:  rd_next = bias_reg;
                default:   map_next = 1'b0;
            endcase
        end
    end

    // zero-wait slave: data is latched in setup, answered in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !map_next;
            if (setup && !pwrite)
                prdata_reg <= rd_next;
        end
    end

    // software settings; out-of-range pulse widths are dropped, the bias keeps the whole word, other fields keep only their low bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            func_reg <= 3'h0;
            adj_reg  <= 16'h0000;
            mode_reg <= MODE_RST;
            pw_reg   <= PW_RST;
            bias_reg <= 32'h0000_0000;
        end
        else if (wr)
        begin
            case (idx)
                IDX_FUNC: func_reg <= pwdata[2:0];
                IDX_ADJ:  adj_reg  <= pwdata[15:0];
                IDX_MODE: mode_reg <= pwdata[3:0];
                IDX_PW:
                    if (pwdata[31:0] >= 32'(PW_MIN) && pwdata[31:0] <= 32'(PW_MAX))
                        pw_reg <= pwdata[13:0];
                IDX_BIAS: bias_reg <= pwdata;
                default:  ;
            endcase
        end
    end

    // point table, zero after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NPTS; i++)
            begin
                attr_mem[i] <= 3'h0;
                tgt_mem[i]  <= 32'h0000_0000;
            end
        end
        else if (wr)
        begin
            if (in_tbl(idx, IDX_ATTR0) && pwdata[31:0] <= 32'(ATTR_MAX))
                attr_mem[tbl_off(idx, IDX_ATTR0)] <= pwdata[2:0];
            if (in_tbl(idx, IDX_TGT0))
                tgt_mem[tbl_off(idx, IDX_TGT0)] <= pwdata;
        end
    end

    // comparison run state and target point
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            pt_reg    <= 5'h00;
        end
        else if (func_wr && rise[F_EN])
        begin
            state_reg <= ST_RUN;
            pt_reg    <= 5'h00;
        end
        else if (!func_reg[F_EN] || (func_wr && !pwdata[F_EN]))
        begin
            state_reg <= ST_IDLE;
            pt_reg    <= 5'h00;
        end
        else if (hit)
        begin
            if (!last_pt)
                pt_reg <= pt_reg + 5'h01;
            else
            begin
                pt_reg <= 5'h00;
                if (!mode_reg[M_CYC])
                    state_reg <= ST_IDLE;
            end
        end
    end

    // position counter; commands apply one cycle after their write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pos_reg <= 32'h0000_0000;
        else if (org_pend_reg)
            pos_reg <= bias_reg;
        else if (adj_pend_reg)
            pos_reg <= pos_reg + {16'h0000, adj_reg};
        else if (hit && mode_reg[M_INCR])
            pos_reg <= 32'h0000_0000;
        else if (pos_up && !pos_dn)
            pos_reg <= pos_reg + 32'h0000_0001;
        else if (pos_dn && !pos_up)
            pos_reg <= pos_reg - 32'h0000_0001;
    end

    // command progress flags; completion wins over a coinciding clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            org_pend_reg <= 1'b0;
            adj_pend_reg <= 1'b0;
            st_org_reg   <= 1'b0;
            st_adj_reg   <= 1'b0;
        end
        else
        begin
            org_pend_reg <= func_wr && rise[F_ORG];
            adj_pend_reg <= func_wr && rise[F_ADJ];
            if (org_pend_reg)
                st_org_reg <= 1'b1;
            else if (func_wr && !pwdata[F_ORG])
                st_org_reg <= 1'b0;
            if (adj_pend_reg)
                st_adj_reg <= 1'b1;
            else if (func_wr && !pwdata[F_ADJ])
                st_adj_reg <= 1'b0;
        end
    end

    // pulse width timer in 100 us units
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pw_left_reg <= 14'h0000;
            ucnt_reg    <= 24'h00_0000;
        end
        else if (!func_reg[F_EN])
        begin
            pw_left_reg <= 14'h0000;
            ucnt_reg    <= 24'h00_0000;
        end
        else if (fire && !mode_reg[M_LVL])
        begin
            pw_left_reg <= pw_reg;
            ucnt_reg    <= 24'h00_0000;
        end
        else if (pw_left_reg != 14'h0000)
        begin
            if (ucnt_reg == 24'(UNIT_CYCLES - 1))
            begin
                ucnt_reg    <= 24'h00_0000;
                pw_left_reg <= pw_left_reg - 14'h0001;
            end
            else
                ucnt_reg <= ucnt_reg + 24'h00_0001;
        end
    end

    // level type latches active until the enable drops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lvl_reg <= 1'b0;
        else if (!func_reg[F_EN])
            lvl_reg <= 1'b0;
        else if (fire && mode_reg[M_LVL])
            lvl_reg <= 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_reg <= 1'b0;
        else
            out_reg <= mode_reg[M_POL] ^ (func_reg[F_EN] && (lvl_reg || pw_left_reg != 14'h0000));
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence org_cmd_s;
        func_wr && rise[F_ORG];
    endsequence
    sequence adj_cmd_s;
        func_wr && rise[F_ADJ];
    endsequence
    en_start_a: assert property (func_wr && rise[F_EN] |=> state_reg == ST_RUN && func_reg[F_EN])
        else $error("enable rise did not start comparison");
    en_off_a: assert property (!func_reg[F_EN] |-> state_reg == ST_IDLE)
        else $error("comparison running while disabled");
    out_idle_a: assert property (!func_reg[F_EN] && $past(!func_reg[F_EN]) |-> out_reg == $past(mode_reg[M_POL]))
        else $error("output not idle while disabled");
    org_load_a: assert property (org_cmd_s |=> !st_org_reg ##1 (st_org_reg && pos_reg == $past(bias_reg)))
        else $error("origin load wrong");
    org_clr_a: assert property (func_wr && !pwdata[F_ORG] && !org_pend_reg |=> !st_org_reg)
        else $error("origin flag not cleared");
    adj_apply_a: assert property (adj_cmd_s ##1 1'b1 |=> st_adj_reg && pos_reg == $past(pos_reg) + {16'h0000, $past(adj_reg)})
        else $error("adjustment wrong");
    adj_clr_a: assert property (func_wr && !pwdata[F_ADJ] && !adj_pend_reg |=> !st_adj_reg)
        else $error("adjust flag not cleared");
    stat_read_a: assert property (setup && !pwrite && idx == IDX_STAT |=> prdata_reg[0] == $past(state_reg == ST_RUN))
        else $error("status bit 0 misread");
    attr_range_a: assert property (attr_mem[pt_reg] <= ATTR_MAX)
        else $error("attribute out of range");
    incr_clear_a: assert property (hit && mode_reg[M_INCR] && !org_pend_reg && !adj_pend_reg |=> pos_reg == 32'h0000_0000)
        else $error("incremental position not cleared");
    single_end_a: assert property (hit && last_pt && !mode_reg[M_CYC] && !func_wr |=> state_reg == ST_IDLE && pt_reg == 5'h00)
        else $error("single mode did not stop");
    pulse_load_a: assert property (fire && !mode_reg[M_LVL] && func_reg[F_EN] |=> pw_left_reg == $past(pw_reg))
        else $error("pulse width not loaded");
endmodule
`default_nettype wire

// ---- core/pcoc_pkg.sv ----
// constants, register indices and types of the position compare output block
package pcoc_pkg;
    localparam int unsigned CLK_NS      = 8;
    localparam int unsigned PW_UNIT_NS  = 100000;
    localparam int unsigned PW_UNIT_CYC = PW_UNIT_NS / CLK_NS;
    localparam int unsigned NPTS        = 20;
    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_FUNC  = 14'h30B0;
    localparam logic [13:0] IDX_ADJ   = 14'h30B1;
    localparam logic [13:0] IDX_STAT  = 14'h30C0;
    localparam logic [13:0] IDX_TPT   = 14'h30C1;
    localparam logic [13:0] IDX_POS   = 14'h30C2;
    localparam logic [13:0] IDX_POS32 = 14'h30C3;
    localparam logic [13:0] IDX_MODE  = 14'h30A0;
    localparam logic [13:0] IDX_PW    = 14'h30A1;
    localparam logic [13:0] IDX_BIAS  = 14'h30A2;
    localparam logic [13:0] IDX_ATTR0 = 14'h3000;
    localparam logic [13:0] IDX_TGT0  = 14'h3020;
    // bit positions
    localparam int unsigned F_EN   = 0;
    localparam int unsigned F_ORG  = 1;
    localparam int unsigned F_ADJ  = 2;
    localparam int unsigned M_INCR = 0;
    localparam int unsigned M_CYC  = 1;
    localparam int unsigned M_POL  = 2;
    localparam int unsigned M_LVL  = 3;
    // limits and reset values
    localparam logic [2:0]  ATTR_MAX  = 3'h6;
    localparam logic [13:0] PW_MIN    = 14'h0001;
    localparam logic [13:0] PW_MAX    = 14'h2710;
    localparam logic [13:0] PW_RST    = 14'h0001;
    localparam logic [3:0]  MODE_RST  = 4'h0;
    localparam logic [4:0]  LAST_PT   = 5'h13;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } pcoc_state_t;
endpackage

// ---- verification/pcoc_pos_src.sv ----
// axis feedback model: emits position count pulses on request
`timescale 1ns/10ps
`default_nettype none
module pcoc_pos_src
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       dn,
    input  wire logic [7:0] steps,
    input  wire logic [3:0] gap,
    output logic            pos_up,
    output logic            pos_dn,
    output logic            busy
);
    logic [7:0] left_reg;
    logic [3:0] wait_reg;
    assign busy = (left_reg != 8'h00);
    // gap spaces the counts so slow and prompt feeds share one path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left_reg <= 8'h00;
            wait_reg <= 4'h0;
            pos_up   <= 1'b0;
            pos_dn   <= 1'b0;
        end
        else if (go && !busy)
        begin
            left_reg <= steps;
            wait_reg <= 4'h0;
            // a new move must not stretch the last count of the previous one
            pos_up   <= 1'b0;
            pos_dn   <= 1'b0;
        end
        else if (busy && wait_reg != 4'h0)
        begin
            wait_reg <= wait_reg - 4'h1;
            pos_up   <= 1'b0;
            pos_dn   <= 1'b0;
        end
        else
        begin
            left_reg <= left_reg - {7'h00, busy};
            wait_reg <= gap;
            pos_up   <= busy && !dn;
            pos_dn   <= busy && dn;
        end
    end
endmodule
`default_nettype wire

// ---- verification/pcoc_top_tb.sv ----
// self-checking bench of the position compare output block
`timescale 1ns/10ps
`default_nettype none
module pcoc_top_tb
    import pcoc_pkg::*;
;
    localparam int unsigned UC = 4;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, v;
    logic        pready, pslverr, pos_up, pos_dn, cmp_out, busy, last_err;
    logic        go = 1'b0, dn = 1'b0;
    logic [7:0]  steps = 8'h00;
    logic [3:0]  gap = 4'h0;
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;

    pcoc_top #(.UNIT_CYCLES(UC)) u_pcoc_top
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pos_up(pos_up), .pos_dn(pos_dn),
        .cmp_out(cmp_out)
    );
    pcoc_pos_src u_pcoc_pos_src
    (
        .pclk(pclk), .presetn(presetn), .go(go), .dn(dn), .steps(steps),
        .gap(gap), .pos_up(pos_up), .pos_dn(pos_dn), .busy(busy)
    );

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        v = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
        xfer(1'b1, idx, wd);
    endtask

    // commands settle a few cycles after the write, so poll with a bound
    task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
        int n;
        n = 0;
        do
            xfer(1'b0, idx, 32'h0000_0000);
        while (v !== exp && ++n < 40);
        chk(v, exp);
    endtask

    task automatic move(input logic down, input logic [7:0] cnt, input logic [3:0] g);
        while (busy)
            @(posedge pclk);
        go    <= 1'b1;
        dn    <= down;
        steps <= cnt;
        gap   <= g;
        @(posedge pclk);
        go    <= 1'b0;
    endtask

    task automatic pulse_chk(input logic act, input int exp);
        int n;
        n = 0;
        while (cmp_out !== act && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (cmp_out === act && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n), 32'(exp));
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(IDX_STAT, 32'h0);
        rd_chk(IDX_TPT, 32'h0);
        for (int i = 0; i < NPTS; i++)
        begin
            rd_chk(IDX_ATTR0 + 14'(i), 32'h0);
            rd_chk(IDX_TGT0 + 14'(i), 32'h0);
        end
        xfer(1'b0, 14'h3FFF, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        wr(IDX_ATTR0, 32'h7);
        rd_chk(IDX_ATTR0, 32'h0);
        wr(IDX_ATTR0, 32'h6);
        rd_chk(IDX_ATTR0, 32'h6);
        wr(IDX_PW, 32'h0);
        wr(IDX_PW, 32'h2711);
        rd_chk(IDX_PW, 32'h1);
        wr(IDX_PW, 32'h2);
        $display("test registers done");
        wr(IDX_BIAS, 32'hFFFF_FF00);
        wr(IDX_FUNC, 32'h2);
        rd_chk(IDX_STAT, 32'h2);
        rd_chk(IDX_POS32, 32'hFFFF_FF00);
        rd_chk(IDX_POS, 32'hFF00);
        wr(IDX_FUNC, 32'h0);
        rd_chk(IDX_STAT, 32'h0);
        wr(IDX_ADJ, 32'h0105);
        wr(IDX_FUNC, 32'h4);
        rd_chk(IDX_STAT, 32'h4);
        rd_chk(IDX_POS32, 32'h5);
        wr(IDX_FUNC, 32'h4);
        wr(IDX_POS, 32'hFFFF);
        wr(IDX_STAT, 32'h0);
        wr(IDX_TPT, 32'h5);
        rd_chk(IDX_POS32, 32'h5);
        rd_chk(IDX_STAT, 32'h4);
        rd_chk(IDX_TPT, 32'h0);
        wr(IDX_FUNC, 32'h0);
        rd_chk(IDX_STAT, 32'h0);
        $display("test origin and adjust done");
        wr(IDX_TGT0, 32'h8);
        wr(IDX_FUNC, 32'h1);
        rd_chk(IDX_STAT, 32'h1);
        chk({31'h0, cmp_out}, 32'h0);
        move(1'b0, 8'h03, 4'h2);
        pulse_chk(1'b1, 2 * UC);
        rd_chk(IDX_TPT, 32'h1);
        rd_chk(IDX_POS32, 32'h8);
        move(1'b1, 8'h08, 4'h0);
        rd_chk(IDX_STAT, 32'h0);
        rd_chk(IDX_TPT, 32'h0);
        wr(IDX_FUNC, 32'h0);
        $display("test single absolute done");
        wr(IDX_MODE, 32'h7);
        wr(IDX_TGT0, 32'h2);
        chk({31'h0, cmp_out}, 32'h1);
        wr(IDX_FUNC, 32'h1);
        move(1'b0, 8'h02, 4'h0);
        pulse_chk(1'b0, 2 * UC);
        rd_chk(IDX_STAT, 32'h1);
        rd_chk(IDX_TPT, 32'h0);
        rd_chk(IDX_POS32, 32'h0);
        wr(IDX_FUNC, 32'h0);
        rd_chk(IDX_STAT, 32'h0);
        chk({31'h0, cmp_out}, 32'h1);
        $display("test cyclic incremental done");
        wr(IDX_MODE, 32'h8);
        wr(IDX_FUNC, 32'h1);
        move(1'b0, 8'h02, 4'h1);
        rd_chk(IDX_TPT, 32'h1);
        // level type must outlast the programmed pulse width
        repeat (20) @(posedge pclk);
        chk({31'h0, cmp_out}, 32'h1);
        rd_chk(IDX_STAT, 32'h1);
        wr(IDX_FUNC, 32'h0);
        rd_chk(IDX_STAT, 32'h0);
        chk({31'h0, cmp_out}, 32'h0);
        $display("test level output done");
        give_verdict();
    end
endmodule
`default_nettype wire
